// >>> verilog/ifp_pkg.sv
package ifp_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned NAT_IW = 3;
  localparam int unsigned ARP_IW = 3;
  localparam int unsigned NAT_N = 1 << NAT_IW;
  localparam int unsigned ARP_N = 1 << ARP_IW;
  // ----------------------------------------
  // header and icmp constants
  // ----------------------------------------
  localparam logic [3:0] IP_VERSION = 4'h4;
  localparam logic [3:0] MIN_IHL = 4'h5;
  localparam logic [7:0] TTL_DEC = 8'h01;
  localparam logic [7:0] PROTO_ICMP = 8'h01;
  localparam logic [7:0] ICMP_ECHO_REPLY = 8'h00;
  localparam logic [7:0] ICMP_UNREACH = 8'h03;
  localparam logic [7:0] ICMP_QUENCH = 8'h04;
  localparam logic [7:0] ICMP_REDIRECT = 8'h05;
  localparam logic [7:0] ICMP_ECHO_REQ = 8'h08;
  localparam logic [7:0] ICMP_TIME_EXC = 8'h0b;
  localparam logic [7:0] ICMP_PARAM = 8'h0c;
  localparam logic [7:0] CODE_NET = 8'h00;
  localparam logic [7:0] CODE_HOST = 8'h01;
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic [31:0] ADDR_BCAST = 32'hffffffff;
  localparam logic [31:0] ADDR_ZERO = 32'h00000000;
  localparam logic [3:0] CLASS_D_TOP = 4'he;
  localparam logic [7:0] LOOP_TOP = 8'h7f;
  localparam logic [12:0] FRAG_FIRST = 13'h0000;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ACT_LOCAL = 2'h0,
    ACT_FWD = 2'h1,
    ACT_DROP = 2'h2
  } ifp_act_t;
  typedef enum logic {
    IFC_CUST = 1'b0,
    IFC_OP = 1'b1
  } ifp_ifc_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROUTE = 3'h1,
    ST_XLATE = 3'h3,
    ST_RESOLVE = 3'h2,
    ST_EMIT = 3'h6
  } ifp_state_t;
  typedef struct packed {
    ifp_ifc_t ingress;
    logic [3:0] version;
    logic [3:0] ihl;
    logic [7:0] ttl;
    logic [7:0] proto;
    logic [7:0] icmp_type;
    logic [12:0] frag_off;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] sport;
    logic [15:0] dport;
  } ifp_pkt_t;
  typedef struct packed {
    logic [31:0] pub_addr;
    logic [31:0] op_net;
    logic [31:0] op_mask;
    logic [31:0] priv_addr;
    logic [31:0] cust_net;
    logic [31:0] cust_mask;
    logic [31:0] def_rtr;
    logic def_rtr_ok;
    logic [31:0] ir_net;
    logic [31:0] ir_mask;
    logic [31:0] ir_addr;
    logic ir_ok;
    logic op_hairpin;
    logic [47:0] op_mac;
    logic [47:0] cust_mac;
  } ifp_cfg_t;
  typedef struct packed {
    ifp_ifc_t ifc;
    logic [31:0] ip;
    logic [47:0] mac;
  } ifp_arp_t;
  typedef struct packed {
    ifp_act_t act;
    ifp_ifc_t egress;
    logic [7:0] ttl;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] nhop;
    logic [47:0] dmac;
    logic [47:0] smac;
    logic icmp_gen;
    logic [7:0] icmp_type;
    logic [7:0] icmp_code;
  } ifp_out_t;
endpackage : ifp_pkg

// >>> verilog/ifp_forward.sv
`timescale 1ns/100ps

module ifp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // fill side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic nfull_q, nempty_q;
  logic push, pop;

  assign wr_ready_out = nfull_q;
  assign rd_valid_out = nempty_q;
  assign rd_data_out = mem[rp_q];

  always_comb begin
    push = wr_valid_in && nfull_q;
    pop = rd_ready_in && nempty_q;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // memory has no reset; only written slots are ever read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_q] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      nfull_q <= 1'b1;
      nempty_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      nfull_q <= cnt_d != FULL_CNT;
      nempty_q <= cnt_d != '0;
    end
  end
endmodule : ifp_fifo

module ifp_forward (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // configuration, held steady while traffic flows
  input wire ifp_pkg::ifp_cfg_t cfg_in,
  // address resolution learning
  input wire logic arp_learn_in,
  input wire ifp_pkg::ifp_arp_t arp_entry_in,
  // packet headers in
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire ifp_pkg::ifp_pkt_t in_pkt_in,
  // forwarding decisions out
  output logic out_valid_out,
  input wire logic out_ready_in,
  output ifp_pkg::ifp_out_t out_desc_out
);
  import ifp_pkg::*;

  // ----------------------------------------
  // input buffer
  // ----------------------------------------
  logic fifo_vld, fifo_pop, fifo_rdy;
  logic [$bits(ifp_pkt_t)-1:0] fifo_data;
  ifp_pkt_t head;

  // full fifo holds off the source; no packet is ever lost to congestion
  ifp_fifo #(
    .WIDTH($bits(ifp_pkt_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .wr_valid_in(in_valid_in),
    .wr_ready_out(fifo_rdy),
    .wr_data_in(in_pkt_in),
    .rd_valid_out(fifo_vld),
    .rd_ready_in(fifo_pop),
    .rd_data_out(fifo_data)
  );
  assign in_ready_out = fifo_rdy;
  assign head = ifp_pkt_t'(fifo_data);

  // ----------------------------------------
  // state
  // ----------------------------------------
  ifp_state_t st_q, st_d;
  ifp_pkt_t pkt_q, pkt_d;
  ifp_act_t act_q, act_d;
  ifp_ifc_t egr_q, egr_d;
  logic [31:0] nh_q, nh_d;
  logic [47:0] dmac_q, dmac_d;
  logic igen_q, igen_d;
  logic [7:0] ityp_q, ityp_d, icod_q, icod_d;
  ifp_out_t out_q, out_d;
  logic ovld_q, ovld_d;

  logic nat_v_q [NAT_N];
  logic [15:0] nat_port_q [NAT_N];
  logic [31:0] nat_ip_q [NAT_N];
  logic nat_we;
  logic [NAT_IW-1:0] nat_wi, nat_ri;

  logic arp_v_q [ARP_N];
  ifp_arp_t arp_e_q [ARP_N];
  logic [ARP_IW-1:0] arp_wp_q, arp_wp_d;
  logic [ARP_N-1:0] arp_hit, arp_same;

  assign fifo_pop = st_q == ST_IDLE;
  assign out_valid_out = ovld_q;
  assign out_desc_out = out_q;

  // ----------------------------------------
  // address resolution table
  // ----------------------------------------
  for (genvar i = 0; i < ARP_N; i++) begin : g_arp
    assign arp_hit[i] = arp_v_q[i] && arp_e_q[i].ifc == egr_q &&
                        arp_e_q[i].ip == nh_q;
    assign arp_same[i] = arp_v_q[i] &&
                         arp_e_q[i].ifc == arp_entry_in.ifc &&
                         arp_e_q[i].ip == arp_entry_in.ip;
  end

  // ----------------------------------------
  // packet classification
  // ----------------------------------------
  logic hdr_ok, bcast, mcast, src_bad, icmp_err, frag_late;
  logic on_cust, on_op, in_ir, to_me, nat_hit, quiet;
  logic [47:0] arp_mac;
  logic arp_any;
  logic [ARP_IW-1:0] arp_wi;

  always_comb begin
    hdr_ok = pkt_q.version == IP_VERSION && pkt_q.ihl >= MIN_IHL;
    bcast = pkt_q.dst == ADDR_BCAST ||
            ((pkt_q.dst & cfg_in.cust_mask) == cfg_in.cust_net &&
             (pkt_q.dst | cfg_in.cust_mask) == ADDR_BCAST);
    mcast = pkt_q.dst[31:28] == CLASS_D_TOP;
    src_bad = pkt_q.src == ADDR_ZERO || pkt_q.src == ADDR_BCAST ||
              pkt_q.src[31:24] == LOOP_TOP ||
              pkt_q.src[31:28] >= CLASS_D_TOP;
    icmp_err = pkt_q.proto == PROTO_ICMP &&
               (pkt_q.icmp_type == ICMP_UNREACH ||
                pkt_q.icmp_type == ICMP_QUENCH ||
                pkt_q.icmp_type == ICMP_REDIRECT ||
                pkt_q.icmp_type == ICMP_TIME_EXC ||
                pkt_q.icmp_type == ICMP_PARAM);
    frag_late = pkt_q.frag_off != FRAG_FIRST;
    // an error for any of these would only add noise or loops
    quiet = icmp_err || bcast || mcast || src_bad || frag_late;
    on_cust = (pkt_q.dst & cfg_in.cust_mask) == cfg_in.cust_net;
    on_op = (pkt_q.dst & cfg_in.op_mask) == cfg_in.op_net;
    in_ir = cfg_in.ir_ok &&
            (pkt_q.dst & cfg_in.ir_mask) == cfg_in.ir_net;
    to_me = pkt_q.ingress == IFC_OP ? pkt_q.dst == cfg_in.pub_addr
                                    : pkt_q.dst == cfg_in.priv_addr;
    nat_ri = pkt_q.dport[NAT_IW-1:0];
    nat_wi = pkt_q.sport[NAT_IW-1:0];
    nat_hit = nat_v_q[nat_ri] && nat_port_q[nat_ri] == pkt_q.dport &&
              pkt_q.dst == cfg_in.pub_addr;
    arp_any = |arp_hit;
    arp_mac = '0;
    for (int k = 0; k < ARP_N; k++) begin
      if (arp_hit[k]) begin
        arp_mac = arp_e_q[k].mac;
      end
    end
    arp_wi = arp_wp_q;
    for (int k = 0; k < ARP_N; k++) begin
      if (arp_same[k]) begin
        arp_wi = ARP_IW'(k);
      end
    end
  end

  // ----------------------------------------
  // sequencing and decisions
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    pkt_d = pkt_q;
    act_d = act_q;
    egr_d = egr_q;
    nh_d = nh_q;
    dmac_d = dmac_q;
    igen_d = igen_q;
    ityp_d = ityp_q;
    icod_d = icod_q;
    out_d = out_q;
    ovld_d = ovld_q;
    nat_we = 1'b0;
    arp_wp_d = arp_wp_q;
    if (arp_learn_in && !(|arp_same)) begin
      arp_wp_d = arp_wp_q + 1'b1;
    end
    case (st_q)
      ST_IDLE: begin
        if (fifo_vld) begin
          pkt_d = head;
          igen_d = 1'b0;
          ityp_d = CODE_ZERO;
          icod_d = CODE_ZERO;
          dmac_d = '0;
          // operator traffic is translated back before routing
          st_d = head.ingress == IFC_OP ? ST_XLATE : ST_ROUTE;
        end
      end
      ST_ROUTE: begin
        act_d = ACT_FWD;
        egr_d = IFC_CUST;
        nh_d = pkt_q.dst;
        ityp_d = ICMP_UNREACH;
        icod_d = CODE_NET;
        if (!hdr_ok) begin
          act_d = ACT_DROP;
          ityp_d = ICMP_PARAM;
        end else if (bcast) begin
          act_d = ACT_LOCAL;
        end else if (to_me) begin
          act_d = ACT_LOCAL;
        end else if (mcast) begin
          act_d = ACT_DROP;
        end else if (on_cust) begin
          nh_d = pkt_q.dst;
        end else if (in_ir) begin
          nh_d = cfg_in.ir_addr;
        end else if (on_op) begin
          egr_d = IFC_OP;
        end else if (cfg_in.def_rtr_ok) begin
          egr_d = IFC_OP;
          nh_d = cfg_in.def_rtr;
        end else begin
          act_d = ACT_DROP;
        end
        if (act_d == ACT_FWD && pkt_q.ingress == IFC_OP &&
            egr_d == IFC_OP && !cfg_in.op_hairpin) begin
          act_d = ACT_DROP;
        end
        if (act_d == ACT_FWD && pkt_q.ttl <= TTL_DEC) begin
          act_d = ACT_DROP;
          ityp_d = ICMP_TIME_EXC;
          icod_d = CODE_ZERO;
        end
        if (act_d == ACT_DROP) begin
          igen_d = !quiet && !(pkt_q.ingress == IFC_OP &&
                               ityp_d == ICMP_UNREACH);
          st_d = ST_EMIT;
        end else if (act_d == ACT_LOCAL) begin
          igen_d = pkt_q.proto == PROTO_ICMP &&
                   pkt_q.icmp_type == ICMP_ECHO_REQ;
          ityp_d = ICMP_ECHO_REPLY;
          icod_d = CODE_ZERO;
          st_d = ST_EMIT;
        end else if (pkt_q.ingress == IFC_CUST && egr_d == IFC_OP) begin
          st_d = ST_XLATE;
        end else begin
          st_d = ST_RESOLVE;
        end
      end
      ST_XLATE: begin
        if (pkt_q.ingress == IFC_OP) begin
          if (nat_hit) begin
            pkt_d.dst = nat_ip_q[nat_ri];
          end
          st_d = ST_ROUTE;
        end else begin
          // port kept as is, so one private pair maps to one public pair
          nat_we = 1'b1;
          pkt_d.src = cfg_in.pub_addr;
          st_d = ST_RESOLVE;
        end
      end
      ST_RESOLVE: begin
        if (arp_any) begin
          dmac_d = arp_mac;
        end else begin
          act_d = ACT_DROP;
          ityp_d = ICMP_UNREACH;
          icod_d = CODE_HOST;
          igen_d = !quiet && pkt_q.ingress != IFC_OP;
        end
        st_d = ST_EMIT;
      end
      ST_EMIT: begin
        if (!ovld_q) begin
          ovld_d = 1'b1;
          out_d.act = act_q;
          out_d.egress = egr_q;
          out_d.ttl = act_q == ACT_FWD ? pkt_q.ttl - TTL_DEC
                                       : pkt_q.ttl;
          out_d.src = pkt_q.src;
          out_d.dst = pkt_q.dst;
          out_d.nhop = nh_q;
          out_d.dmac = dmac_q;
          out_d.smac = egr_q == IFC_OP ? cfg_in.op_mac
                                       : cfg_in.cust_mac;
          out_d.icmp_gen = igen_q;
          out_d.icmp_type = ityp_q;
          out_d.icmp_code = icod_q;
        end else if (out_ready_in) begin
          ovld_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
        ovld_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
      pkt_q <= '0;
      act_q <= ACT_LOCAL;
      egr_q <= IFC_CUST;
      nh_q <= '0;
      dmac_q <= '0;
      igen_q <= 1'b0;
      ityp_q <= '0;
      icod_q <= '0;
      out_q <= '0;
      ovld_q <= 1'b0;
      arp_wp_q <= '0;
    end else begin
      st_q <= st_d;
      pkt_q <= pkt_d;
      act_q <= act_d;
      egr_q <= egr_d;
      nh_q <= nh_d;
      dmac_q <= dmac_d;
      igen_q <= igen_d;
      ityp_q <= ityp_d;
      icod_q <= icod_d;
      out_q <= out_d;
      ovld_q <= ovld_d;
      arp_wp_q <= arp_wp_d;
    end
  end

  // ----------------------------------------
  // translation and resolution tables
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    for (int k = 0; k < NAT_N; k++) begin
      if (rst_in) begin
        nat_v_q[k] <= 1'b0;
        nat_port_q[k] <= '0;
        nat_ip_q[k] <= '0;
      end else if (nat_we && nat_wi == NAT_IW'(k)) begin
        nat_v_q[k] <= 1'b1;
        nat_port_q[k] <= pkt_q.sport;
        nat_ip_q[k] <= pkt_q.src;
      end
    end
    for (int k = 0; k < ARP_N; k++) begin
      if (rst_in) begin
        arp_v_q[k] <= 1'b0;
        arp_e_q[k] <= '0;
      end else if (arp_learn_in && arp_wi == ARP_IW'(k)) begin
        arp_v_q[k] <= 1'b1;
        arp_e_q[k] <= arp_entry_in;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_cust_to_xlate: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q == ST_ROUTE && act_d == ACT_FWD && pkt_q.ingress == IFC_CUST &&
    egr_d == IFC_OP |=> st_q == ST_XLATE ##1 st_q == ST_RESOLVE)
    else $error("outbound packet skipped translation");
  a_cust_no_xlate: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q == ST_ROUTE && act_d == ACT_FWD && egr_d == IFC_CUST
    |=> st_q == ST_RESOLVE)
    else $error("customer-bound packet went to translation");
  a_op_xlate_first: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q == ST_IDLE && fifo_vld && head.ingress == IFC_OP
    |=> st_q == ST_XLATE ##1 st_q == ST_ROUTE)
    else $error("operator packet routed before translation");
  a_ttl_forward: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(ovld_q) && out_q.act == ACT_FWD
    |-> out_q.ttl == $past(pkt_q.ttl) - TTL_DEC)
    else $error("forwarded ttl not decreased by one");
  a_ttl_local: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(ovld_q) && out_q.act == ACT_LOCAL
    |-> out_q.ttl == $past(pkt_q.ttl))
    else $error("local ttl changed");
  a_bcast_local: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(ovld_q) && out_q.dst == ADDR_BCAST
    |-> out_q.act != ACT_FWD)
    else $error("broadcast forwarded");
  a_src_mac: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovld_q && out_q.act == ACT_FWD |-> out_q.smac ==
    (out_q.egress == IFC_OP ? cfg_in.op_mac : cfg_in.cust_mac))
    else $error("wrong source mac");
  a_frag_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(ovld_q) && out_q.act == ACT_DROP &&
    $past(pkt_q.frag_off) != FRAG_FIRST |-> !out_q.icmp_gen)
    else $error("icmp error for later fragment");
  a_op_unreach: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovld_q && out_q.icmp_gen && pkt_q.ingress == IFC_OP
    |-> out_q.icmp_type != ICMP_UNREACH)
    else $error("unreachable toward operator side");
  a_emit_bound: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q == ST_IDLE && fifo_vld |-> ##[2:6] ovld_q)
    else $error("decision not presented in time");
endmodule : ifp_forward

// >>> verif/ifp_sink.sv
`timescale 1ns/100ps

module ifp_sink (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pacing chosen by the bench
  input wire logic stall_in,
  input wire logic slow_in,
  // decision stream from the block
  input wire logic out_valid_in,
  output logic out_ready_out,
  input wire ifp_pkg::ifp_out_t desc_in,
  // last decision taken and how many
  output ifp_pkg::ifp_out_t last_out,
  output logic [15:0] cnt_out
);
  import ifp_pkg::*;
  logic phase_q;
  // a slow consumer only takes every other cycle, so the block must hold
  assign out_ready_out = !stall_in && (!slow_in || phase_q);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_q <= 1'h0;
      cnt_out <= 16'h0000;
      last_out <= '0;
    end else begin
      phase_q <= !phase_q;
      if (out_valid_in && out_ready_out) begin
        last_out <= desc_in;
        cnt_out <= cnt_out + 16'h0001;
      end
    end
  end
endmodule : ifp_sink

// >>> verif/tb_ifp_forward.sv
`timescale 1ns/100ps

module tb_ifp_forward;
  import ifp_pkg::*;
  logic mclk_in = 1'h0;
  logic rst_in = 1'h1;
  ifp_cfg_t cfg;
  logic arp_learn = 1'h0;
  ifp_arp_t arp_entry = '0;
  logic in_valid = 1'h0;
  logic in_ready;
  ifp_pkt_t in_pkt = '0;
  logic out_valid, out_ready, stall = 1'h0, slow = 1'h0;
  ifp_out_t out_desc, last;
  logic [15:0] cnt;
  int n_errors = 0, num_checks = 0, cyc = 0;
  localparam logic [47:0] RTR_MAC = 48'h0200000000a1;
  localparam logic [47:0] HOST_MAC = 48'h0200000000b2;
  localparam logic [31:0] HOST = 32'hc0a80105;
  localparam logic [31:0] FAR = 32'h08080808;
  localparam logic [31:0] IR = 32'hc0a801fe;
  localparam logic [47:0] IR_MAC = 48'h0200000000d3;
  localparam logic [31:0] OPN = 32'hc6336409;

  ifp_forward i_ifp_forward (.mclk_in(mclk_in), .rst_in(rst_in),
    .cfg_in(cfg), .arp_learn_in(arp_learn), .arp_entry_in(arp_entry),
    .in_valid_in(in_valid), .in_ready_out(in_ready), .in_pkt_in(in_pkt),
    .out_valid_out(out_valid), .out_ready_in(out_ready),
    .out_desc_out(out_desc));
  ifp_sink i_ifp_sink (.clk_in(mclk_in), .rst_in(rst_in), .stall_in(stall),
    .slow_in(slow), .out_valid_in(out_valid), .out_ready_out(out_ready),
    .desc_in(out_desc), .last_out(last), .cnt_out(cnt));

  always #20 mclk_in = !mclk_in;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [63:0] e, g);
    num_checks++;
    if (e !== g) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // whole run is a few hundred cycles; this only cuts a hang
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  function automatic ifp_pkt_t mk(ifp_ifc_t ig, logic [7:0] ttl, pr, ty,
    logic [12:0] fr, logic [31:0] s, d, logic [15:0] sp, dp);
    mk = '{ig, IP_VERSION, MIN_IHL, ttl, pr, ty, fr, s, d, sp, dp};
  endfunction : mk

  task automatic learn(input ifp_ifc_t f, input logic [31:0] ip,
    input logic [47:0] mac);
    @(posedge mclk_in);
    arp_learn <= 1'h1;
    arp_entry <= '{f, ip, mac};
    @(posedge mclk_in);
    arp_learn <= 1'h0;
  endtask : learn

  task automatic send(input ifp_pkt_t p);
    int k;
    k = 0;
    @(posedge mclk_in);
    in_valid <= 1'h1;
    in_pkt <= p;
    @(posedge mclk_in);
    while (in_ready !== 1'h1 && k < 50) begin
      @(posedge mclk_in);
      k++;
    end
    in_valid <= 1'h0;
  endtask : send

  task automatic wait_cnt(input logic [15:0] n);
    int k;
    k = 0;
    while (cnt !== n && k < 400) begin
      @(posedge mclk_in);
      k++;
    end
    chk("taken", n, cnt);
  endtask : wait_cnt

  task automatic run(input ifp_pkt_t p, input ifp_act_t a,
    input ifp_ifc_t eg, input logic [31:0] s, d, nh,
    input logic [47:0] dm, sm, input logic ig, input logic [7:0] ty, cd);
    logic [15:0] c0;
    c0 = cnt;
    send(p);
    wait_cnt(c0 + 16'h0001);
    chk("act", a, last.act);
    chk("icmp_gen", ig, last.icmp_gen);
    if (ig) begin
      chk("icmp_type", ty, last.icmp_type);
      chk("icmp_code", cd, last.icmp_code);
    end
    if (a == ACT_FWD) begin
      chk("egress", eg, last.egress);
      chk("ttl", p.ttl - TTL_DEC, last.ttl);
      chk("src", s, last.src);
      chk("nhop", nh, last.nhop);
      chk("dmac", dm, last.dmac);
      chk("smac", sm, last.smac);
    end
    if (a != ACT_DROP) begin
      chk("dst", d, last.dst);
    end
    if (a == ACT_LOCAL) begin
      chk("ttl", p.ttl, last.ttl);
    end
  endtask : run

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_out_and_back;
    run(mk(IFC_CUST, 8'h40, 8'h11, 8'h00, 13'h0, HOST, FAR, 16'h1234,
      16'h0050), ACT_FWD, IFC_OP, cfg.pub_addr, FAR, cfg.def_rtr, RTR_MAC,
      cfg.op_mac, 1'h0, 8'h00, 8'h00);
    run(mk(IFC_OP, 8'h30, 8'h11, 8'h00, 13'h0, FAR, cfg.pub_addr, 16'h0050,
      16'h1234), ACT_FWD, IFC_CUST, FAR, HOST, HOST, HOST_MAC,
      cfg.cust_mac, 1'h0, 8'h00, 8'h00);
  endtask : sc_out_and_back

  task automatic sc_lan_to_lan;
    run(mk(IFC_CUST, 8'h02, 8'h06, 8'h00, 13'h0, 32'hc0a80107, HOST,
      16'h0999, 16'h0050), ACT_FWD, IFC_CUST, 32'hc0a80107, HOST, HOST,
      HOST_MAC, cfg.cust_mac, 1'h0, 8'h00, 8'h00);
    run(mk(IFC_CUST, 8'h20, 8'h06, 8'h00, 13'h0, HOST, 32'hc0a80109,
      16'h0999, 16'h0050), ACT_DROP, IFC_CUST, 0, 0, 0, 0, 0, 1'h1,
      ICMP_UNREACH, CODE_HOST);
    // off-link customer destination behind the internal router
    @(posedge mclk_in);
    cfg.ir_ok <= 1'h1;
    cfg.ir_net <= 32'h0a560000;
    cfg.ir_mask <= 32'hfffff000;
    cfg.ir_addr <= IR;
    learn(IFC_CUST, IR, IR_MAC);
    run(mk(IFC_CUST, 8'h20, 8'h06, 8'h00, 13'h0, HOST, 32'h0a560105,
      16'h0999, 16'h0050), ACT_FWD, IFC_CUST, HOST, 32'h0a560105, IR,
      IR_MAC, cfg.cust_mac, 1'h0, 8'h00, 8'h00);
  endtask : sc_lan_to_lan

  task automatic sc_local;
    run(mk(IFC_CUST, 8'h01, PROTO_ICMP, ICMP_ECHO_REQ, 13'h0, HOST,
      cfg.priv_addr, 16'h0, 16'h0), ACT_LOCAL, IFC_CUST, 0, cfg.priv_addr, 0,
      0, 0, 1'h1, ICMP_ECHO_REPLY, CODE_ZERO);
    run(mk(IFC_OP, 8'h09, 8'h11, 8'h00, 13'h0, FAR, cfg.pub_addr, 16'h0050,
      16'h0055), ACT_LOCAL, IFC_OP, 0, cfg.pub_addr, 0, 0, 0, 1'h0,
      8'h00, 8'h00);
    run(mk(IFC_CUST, 8'h05, 8'h11, 8'h00, 13'h0, HOST, ADDR_BCAST, 16'h0044,
      16'h0043), ACT_LOCAL, IFC_CUST, 0, ADDR_BCAST, 0, 0, 0, 1'h0,
      8'h00, 8'h00);
  endtask : sc_local

  task automatic sc_drops;
    ifp_pkt_t p;
    p = mk(IFC_CUST, 8'h01, 8'h11, 8'h00, 13'h0, HOST, FAR, 16'h1, 16'h2);
    run(p, ACT_DROP, IFC_OP, 0, 0, 0, 0, 0, 1'h1, ICMP_TIME_EXC,
      CODE_ZERO);
    p.version = 4'h6;
    run(p, ACT_DROP, IFC_OP, 0, 0, 0, 0, 0, 1'h1, ICMP_PARAM,
      CODE_ZERO);
    p = mk(IFC_OP, 8'h40, 8'h11, 8'h00, 13'h0, FAR, 32'hc6336409, 16'h1,
      16'h2);
    run(p, ACT_DROP, IFC_OP, 0, 0, 0, 0, 0, 1'h0, 8'h00, 8'h00);
    // hairpin enabled: operator traffic goes straight back out
    @(posedge mclk_in);
    cfg.op_hairpin <= 1'h1;
    learn(IFC_OP, OPN, RTR_MAC);
    run(p, ACT_FWD, IFC_OP, FAR, OPN, OPN, RTR_MAC, cfg.op_mac, 1'h0,
      8'h00, 8'h00);
    // operator ingress errors: time exceeded allowed, unreachable not
    p = mk(IFC_OP, 8'h01, 8'h11, 8'h00, 13'h0, FAR, HOST, 16'h1, 16'h2);
    run(p, ACT_DROP, IFC_OP, 0, 0, 0, 0, 0, 1'h1, ICMP_TIME_EXC,
      CODE_ZERO);
    p.ttl = 8'h40;
    p.dst = 32'hc0a80109;
    run(p, ACT_DROP, IFC_OP, 0, 0, 0, 0, 0, 1'h0, 8'h00, 8'h00);
    @(posedge mclk_in);
    cfg.op_hairpin <= 1'h0;
    cfg.def_rtr_ok <= 1'h0;
    p = mk(IFC_CUST, 8'h40, 8'h11, 8'h00, 13'h0, HOST, FAR, 16'h1, 16'h2);
    run(p, ACT_DROP, IFC_OP, 0, 0, 0, 0, 0, 1'h1, ICMP_UNREACH,
      CODE_NET);
    p.frag_off = 13'h0008;
    run(p, ACT_DROP, IFC_OP, 0, 0, 0, 0, 0, 1'h0, 8'h00, 8'h00);
    @(posedge mclk_in);
    cfg.def_rtr_ok <= 1'h1;
  endtask : sc_drops

  task automatic sc_fill;
    int acc;
    logic [15:0] c0;
    acc = 0;
    c0 = cnt;
    @(posedge mclk_in);
    stall <= 1'h1;
    in_valid <= 1'h1;
    in_pkt <= mk(IFC_OP, 8'h40, 8'h11, 8'h00, 13'h0, FAR, cfg.pub_addr,
      16'h1, 16'h0077);
    repeat (40) begin
      @(posedge mclk_in);
      if (in_ready === 1'h1) begin
        acc++;
      end
      in_pkt.ttl <= 8'h40 + acc[7:0];
    end
    in_valid <= 1'h0;
    chk("in_ready", 1'h0, in_ready);
    // fifo full plus the one header held in the emit stage
    chk("fill", FIFO_DEPTH + 1, acc);
    slow <= 1'h1;
    stall <= 1'h0;
    wait_cnt(c0 + acc[15:0]);
    chk("last ttl", 8'h3f + acc[7:0], last.ttl);
    slow <= 1'h0;
  endtask : sc_fill

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cfg = '0;
    cfg.pub_addr = 32'hc6336402;
    cfg.op_net = 32'hc6336400;
    cfg.op_mask = 32'hffffff00;
    cfg.priv_addr = 32'hc0a80101;
    cfg.cust_net = 32'hc0a80100;
    cfg.cust_mask = 32'hffffff00;
    cfg.def_rtr = 32'hc6336401;
    cfg.def_rtr_ok = 1'h1;
    cfg.op_mac = 48'h0200000000c1;
    cfg.cust_mac = 48'h0200000000c2;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'h0;
    @(posedge mclk_in);
    chk("ready after reset", 1'h1, in_ready);
    chk("valid after reset", 1'h0, out_valid);
    learn(IFC_OP, cfg.def_rtr, RTR_MAC);
    learn(IFC_CUST, HOST, HOST_MAC);
    sc_out_and_back();
    sc_lan_to_lan();
    sc_local();
    sc_drops();
    sc_fill();
    report_and_stop();
  end
endmodule : tb_ifp_forward
